// *** rtl/osf_pkg.sv ***
// Constants, carriers and state types of the octal switch fault control.
// Assumes a 10 MHz system clock and a serial link clocked by the host.
// How it works
// - Limit mode resumes output once short clears
// - Latched overcurrent output stays off until write
// - Persisting short: on for delay, then off
// - One select input governs all eight outputs
// - Logic undervoltage: outputs off, status all off
// - Load supply low never shuts outputs down
// - Command one means off, zero means on
// - Open load on off output reports zero
// - Overcurrent on on output reports one
// - Overcurrent reported whatever the select level
// - Select high keeps overcurrent output current limited
// - Overtemperature turns off only that output
// - Overvoltage latches all off until a write once it clears
// - Each output has its own status bit
// - Overcurrent shutdown only after delay since write
// - Status after overvoltage is all ones
// - Open load masked until filter delay expires
package osf_pkg;

	// Channel count and timer width
	localparam int NUM_OUT = 8;
	localparam int TMR_W = 10;
	localparam int CNT_W = 3;

	// System clock rate in kHz
	localparam int CLK_KHZ = 10000;

	// Least shutdown delay after a write, in microseconds
	localparam int SHUT_DELAY_US = 70;
	// Least open load filter delay, in microseconds
	localparam int FILTER_US = 25;

	// Delays as clock counts, rounded up
	localparam int SHUT_DELAY_CYC = (SHUT_DELAY_US * CLK_KHZ + 999) / 1000;
	localparam int FILTER_CYC = (FILTER_US * CLK_KHZ + 999) / 1000;
	localparam logic [TMR_W-1:0] SHUT_DELAY_CNT = TMR_W'(SHUT_DELAY_CYC);
	localparam logic [TMR_W-1:0] FILTER_CNT = TMR_W'(FILTER_CYC);
	localparam logic [TMR_W-1:0] TMR_ONE = 10'h001;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

	// Reset values: every output off, status all off
	localparam logic [NUM_OUT-1:0] CMD_ALL_OFF = 8'hFF;
	localparam logic [NUM_OUT-1:0] STATUS_ALL_OFF = 8'hFF;
	localparam logic [NUM_OUT-1:0] WORD_ZERO = 8'h00;
	localparam logic [1:0] RST_PIPE_IDLE = 2'h0;

	// Asynchronous inputs, passed together through the synchroniser
	typedef struct packed {
		logic cs_n; // Frame select, low in a frame
		logic short_fault_protect_select; // High: current limit mode
		logic load_supply_ov; // Load supply overvoltage
		logic logic_supply_uv; // Logic supply undervoltage
		logic load_supply_low; // Load supply below rated range
		logic [NUM_OUT-1:0] over_current; // Drain above threshold, on
		logic [NUM_OUT-1:0] open_load; // Drain below threshold, off
		logic [NUM_OUT-1:0] over_temp; // Per output thermal limit
	} osf_pins_type;

	// System clock domain state
	typedef struct packed {
		logic [NUM_OUT-1:0] cmd; // Applied command word, 1 = off
		logic [NUM_OUT-1:0] oc_latch; // Overcurrent shutdown latches
		logic ov_latch; // Overvoltage holds all off
		logic ov_seen; // Overvoltage since last freeze
		logic [NUM_OUT-1:0] oc_seen; // Overcurrent since last freeze
		logic [NUM_OUT-1:0] ol_seen; // Open load since last freeze
		logic [NUM_OUT-1:0] ot_seen; // Overtemperature since last freeze
		logic [NUM_OUT-1:0] status; // Word shifted out in this frame
		logic [TMR_W-1:0] delay_cnt; // Shutdown delay timer
		logic [TMR_W-1:0] filter_cnt; // Open load filter timer
		logic [NUM_OUT-1:0] drive; // Gate drive of the outputs
		logic cs_level; // Previous synchronised select
		logic suspect; // Status accuracy warning
	} osf_state_type;

	// State after reset or logic undervoltage
	localparam osf_state_type STATE_RESET = '{
		cmd: CMD_ALL_OFF,
		status: STATUS_ALL_OFF,
		cs_level: 1'b1,
		default: '0
	};

	// Link clock domain state, cleared while select is high
	typedef struct packed {
		logic [CNT_W-1:0] bit_cnt; // Bits taken in this frame
		logic so; // Serial status bit
	} osf_link_type;

endpackage

// *** rtl/osf_sync.sv ***
// Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes a reset already released in the destination clock domain.
`timescale 1ns/10ps
module osf_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	// Both stages in one state record
	typedef struct packed {
		logic [WIDTH-1:0] meta; // First stage, read by second only
		logic [WIDTH-1:0] stable; // Second stage, safe to use
	} osf_sync_state_type;

	osf_sync_state_type state;
	osf_sync_state_type next_state;

	// Shift the level along the two stages
	always_comb begin
		next_state.meta = d_in;
		next_state.stable = state.meta;
	end

	// Register both stages
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '{meta: RESET_VALUE, stable: RESET_VALUE};
		end else begin
			state <= next_state;
		end
	end

	assign q_out = state.stable;

endmodule

// *** rtl/osf_top.sv ***
// Fault control and serial status of an eight output low side switch.
// Assumes the host frames eight serial clocks under select low, leaves
// at least four system clocks between select fall and the first serial
// edge, and keeps the serial clock still while select is high.
`timescale 1ns/10ps
module osf_top #(
	parameter logic [osf_pkg::TMR_W-1:0] SHUT_DELAY_CNT = osf_pkg::SHUT_DELAY_CNT,
	parameter logic [osf_pkg::TMR_W-1:0] FILTER_CNT = osf_pkg::FILTER_CNT
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic short_fault_protect_select_in,
	input wire logic load_supply_ov_in,
	input wire logic logic_supply_uv_in,
	input wire logic load_supply_low_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] over_current_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] open_load_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] over_temp_in,
	output logic [osf_pkg::NUM_OUT-1:0] out_on_out,
	output logic so_out,
	output logic status_suspect_out
);

	import osf_pkg::*;

	// Reset release pipeline
	logic [1:0] rst_pipe;
	// Synchronised reset used by all but the link state
	logic rst_n;

	// Raw and synchronised pin levels
	osf_pins_type pins_raw;
	osf_pins_type pins;

	// System clock domain state
	osf_state_type state;
	osf_state_type next_state;

	// Link clock domain state
	osf_link_type link;
	osf_link_type next_link;

	// Command shift register on the link clock
	logic [NUM_OUT-1:0] shift_word;
	logic [NUM_OUT-1:0] next_shift_word;

	// Frame edges seen in the system domain
	logic cs_rise;
	logic cs_fall;
	// Timer expiry flags
	logic delay_done;
	logic filter_done;
	// Fault events of this cycle
	logic [NUM_OUT-1:0] oc_ev;
	logic [NUM_OUT-1:0] ol_ev;
	logic [NUM_OUT-1:0] ot_ev;
	// Outputs tripped by overcurrent shutdown
	logic [NUM_OUT-1:0] oc_trip;
	// Status word assembled at freeze
	logic [NUM_OUT-1:0] fault_word;

	// Reset: asserted at once, released after two clock edges
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_pipe <= RST_PIPE_IDLE;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe[1];

	// Gather the pins for the synchroniser
	always_comb begin
		pins_raw.cs_n = cs_n_in;
		pins_raw.short_fault_protect_select = short_fault_protect_select_in;
		pins_raw.load_supply_ov = load_supply_ov_in;
		pins_raw.logic_supply_uv = logic_supply_uv_in;
		pins_raw.load_supply_low = load_supply_low_in;
		pins_raw.over_current = over_current_in;
		pins_raw.open_load = open_load_in;
		pins_raw.over_temp = over_temp_in;
	end

	// Two flip-flops on every asynchronous input
	osf_sync #(
		.WIDTH($bits(osf_pins_type)),
		.RESET_VALUE({1'b1, {($bits(osf_pins_type) - 1){1'b0}}})
	) u_pin_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.d_in(pins_raw),
		.q_out(pins)
	);

	// System domain: frame handling, protection and status
	always_comb begin
		next_state = state;
		// Frame edges from the synchronised select
		cs_rise = pins.cs_n & ~state.cs_level;
		cs_fall = ~pins.cs_n & state.cs_level;
		next_state.cs_level = pins.cs_n;
		// Timer expiry
		delay_done = state.delay_cnt >= SHUT_DELAY_CNT;
		filter_done = state.filter_cnt >= FILTER_CNT;
		// Faults only count in the state they belong to
		oc_ev = pins.over_current & ~state.cmd;
		ol_ev = pins.open_load & state.cmd & {NUM_OUT{filter_done}};
		ot_ev = pins.over_temp & ~state.cmd;
		// Shutdown trips: select low, output driven, delay over
		oc_trip = WORD_ZERO;
		fault_word = WORD_ZERO;

		// Write applied on select rise, timers restart
		if (cs_rise) begin
			next_state.cmd = shift_word;
			next_state.oc_latch = WORD_ZERO;
			next_state.delay_cnt = '0;
			next_state.filter_cnt = '0;
			// Overvoltage released only once the supply is back
			if (!pins.load_supply_ov) begin
				next_state.ov_latch = 1'b0;
			end
		end else begin
			// Timers count up and hold at their limit
			if (!delay_done) begin
				next_state.delay_cnt = state.delay_cnt + TMR_ONE;
			end
			if (!filter_done) begin
				next_state.filter_cnt = state.filter_cnt + TMR_ONE;
			end
			// Latched shutdown only in shutdown mode, after the delay
			if (!pins.short_fault_protect_select && delay_done) begin
				oc_trip = pins.over_current & state.drive;
			end
			// Limit mode never latches, so recovery is automatic
			next_state.oc_latch = state.oc_latch | oc_trip;
		end

		// Overvoltage turns all off at once, set wins over release
		if (pins.load_supply_ov) begin
			next_state.ov_latch = 1'b1;
		end

		// Sticky fault records, a new event wins over the freeze clear
		for (int i = 0; i < NUM_OUT; i++) begin
			// Off output: zero on open load, else echo the one
			if (state.cmd[i]) begin
				fault_word[i] = ~(state.ol_seen[i] | ol_ev[i]);
			end else begin
				// On output: one on overcurrent or overtemperature
				fault_word[i] = state.oc_seen[i] | oc_ev[i] |
					state.ot_seen[i] | ot_ev[i];
			end
		end

		// Freeze status on select fall, then clear the records
		if (cs_fall) begin
			if (state.ov_seen || pins.load_supply_ov) begin
				next_state.status = STATUS_ALL_OFF;
			end else begin
				next_state.status = fault_word;
			end
			next_state.oc_seen = oc_ev;
			next_state.ol_seen = ol_ev;
			next_state.ot_seen = ot_ev;
			next_state.ov_seen = pins.load_supply_ov;
		end else begin
			// Accumulate between freezes
			next_state.oc_seen = state.oc_seen | oc_ev;
			next_state.ol_seen = state.ol_seen | ol_ev;
			next_state.ot_seen = state.ot_seen | ot_ev;
			next_state.ov_seen = state.ov_seen | pins.load_supply_ov;
		end

		// Drive: command zero means on, gated by every shutdown
		next_state.drive = ~next_state.cmd & ~next_state.oc_latch &
			~pins.over_temp & {NUM_OUT{~next_state.ov_latch}};

		// Low load supply only warns, drive stays as commanded
		next_state.suspect = pins.load_supply_low;

		// Logic undervoltage: all off, status reports all off
		if (pins.logic_supply_uv) begin
			next_state = STATE_RESET;
			next_state.cs_level = pins.cs_n;
			next_state.suspect = pins.load_supply_low;
		end
	end

	// Register the system domain state
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Link domain: count bits and present status, MSB first
	always_comb begin
		next_link = link;
		// Status word is frozen well before the first serial edge
		next_link.so = state.status[~link.bit_cnt];
		next_link.bit_cnt = link.bit_cnt + CNT_ONE;
		// Command enters MSB first, matching status order
		next_shift_word = {shift_word[NUM_OUT-2:0], si_in};
	end

	// Bit counter and status bit, cleared while select is high
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	// Command shift register, held after the frame for capture
	always_ff @(posedge sclk_in or negedge rst_n) begin
		if (!rst_n) begin
			shift_word <= CMD_ALL_OFF;
		end else if (!cs_n_in) begin
			shift_word <= next_shift_word;
		end
	end

	// Outputs straight from flip-flops
	assign out_on_out = state.drive;
	assign so_out = link.so;
	assign status_suspect_out = state.suspect;

endmodule

// *** tb/osf_checker.sv ***
// Checker of the switch fault control, bound to its top module.
// Assumes it sees only the top's ports.
`timescale 1ns/10ps
module osf_checker #(
	parameter logic [osf_pkg::TMR_W-1:0] SHUT_DELAY_CNT = osf_pkg::SHUT_DELAY_CNT,
	parameter logic [osf_pkg::TMR_W-1:0] FILTER_CNT = osf_pkg::FILTER_CNT
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic short_fault_protect_select_in,
	input wire logic load_supply_ov_in,
	input wire logic logic_supply_uv_in,
	input wire logic load_supply_low_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] over_current_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] open_load_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] over_temp_in,
	input wire logic [osf_pkg::NUM_OUT-1:0] out_on_out,
	input wire logic so_out,
	input wire logic status_suspect_out
);
	import osf_pkg::*;
	logic [NUM_OUT-1:0] shadow; // Last eight bits shifted in
	logic [23:0] ot_h; // Three past overtemperature samples
	logic quiet; // No overtemperature, overvoltage or logic undervoltage
	logic calm; // Limit mode with no write and no forced off
	assign quiet = over_temp_in == WORD_ZERO && !load_supply_ov_in && !logic_supply_uv_in;
	assign calm = short_fault_protect_select_in && quiet && cs_n_in;
	// Command copy in the link domain
	always_ff @(posedge sclk_in) begin
		if (!cs_n_in) begin
			shadow <= {shadow[NUM_OUT-2:0], si_in};
		end
	end
	// Overtemperature history
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ot_h <= 24'h000000;
		end else begin
			ot_h <= {ot_h[15:0], over_temp_in};
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	// A write framed by cycles free of overtemperature and supply faults
	sequence s_write;
		quiet[*3] ##1 ($rose(cs_n_in) && quiet) ##0 (quiet && cs_n_in)[*8];
	endsequence
	// Overvoltage seen, then gone with no write
	sequence s_ov_gone;
		load_supply_ov_in[*4] ##1 (!load_supply_ov_in && cs_n_in)[*8];
	endsequence
	AST_SO_IDLE: assert property (cs_n_in |-> !so_out)
		else $error("status line not low between frames");
	AST_CMD: assert property (s_write |-> out_on_out == ~shadow)
		else $error("outputs differ from command word");
	AST_UV: assert property (logic_supply_uv_in[*4] |-> out_on_out == WORD_ZERO)
		else $error("outputs on under logic undervoltage");
	AST_OV: assert property (load_supply_ov_in[*4] |-> out_on_out == WORD_ZERO)
		else $error("outputs on under overvoltage");
	AST_OV_LATCH: assert property (s_ov_gone |-> out_on_out == WORD_ZERO)
		else $error("outputs back on without a write");
	AST_OT: assert property ((out_on_out & over_temp_in & ot_h[7:0] & ot_h[15:8] & ot_h[23:16]) == WORD_ZERO)
		else $error("hot output still on");
	AST_LOW: assert property (load_supply_low_in[*4] |-> status_suspect_out)
		else $error("status warning missing");
	AST_LIMIT: assert property (calm[*8] |-> $stable(out_on_out))
		else $error("output changed in limit mode");
endmodule
bind osf_top osf_checker #(
	.SHUT_DELAY_CNT(SHUT_DELAY_CNT),
	.FILTER_CNT(FILTER_CNT)
) osf_checker_i (.*);

// *** tb/osf_host.sv ***
// Host model: frames commands on the serial link, reads status.
// Assumes the switch samples on the serial clock rising edge.
`timescale 1ns/10ps
module osf_host (
	output logic sclk_out,
	output logic cs_n_out,
	output logic si_out,
	input wire logic so_in,
	output logic [osf_pkg::NUM_OUT-1:0] fault_out
);
	import osf_pkg::*;
	logic [NUM_OUT-1:0] prev_cmd; // Word of the previous frame
	// Idle link, serial clock still
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b0;
		si_out = 1'b0;
		prev_cmd = CMD_ALL_OFF;
		fault_out = WORD_ZERO;
		// Select rise clears the link counter before the first frame
		#1 cs_n_out = 1'b1;
	end
	// One frame, eight bits each way
	task automatic xfer(input logic [NUM_OUT-1:0] cmd, output logic [NUM_OUT-1:0] st);
		cs_n_out = 1'b0;
		#437;
		for (int k = NUM_OUT - 1; k >= 0; k--) begin
			si_out = cmd[k];
			#80 sclk_out = 1'b1;
			#80 sclk_out = 1'b0;
			st[k] = so_in;
		end
		#37 cs_n_out = 1'b1;
		si_out = ~si_out;
		fault_out = st ^ prev_cmd;
		prev_cmd = cmd;
	endtask
endmodule

// *** tb/osf_top_tb.sv ***
// Bench of the switch fault control with host model and checker.
// Assumes delay counts shortened to 20 and 8 clocks.
`timescale 1ns/10ps
module osf_top_tb;
	import osf_pkg::*;
	logic clk_in, rstn_in, sfps, ov, uv, low, sclk, cs_n, si, so, sus;
	logic [NUM_OUT-1:0] oc, ol, ot, out, flt, st;
	int err_total, comparisons;
	osf_top #(.SHUT_DELAY_CNT(10'h014), .FILTER_CNT(10'h008)) osf_top_i (.clk_in(clk_in),
		.rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si),
		.short_fault_protect_select_in(sfps), .load_supply_ov_in(ov),
		.logic_supply_uv_in(uv), .load_supply_low_in(low), .over_current_in(oc),
		.open_load_in(ol), .over_temp_in(ot), .out_on_out(out), .so_out(so),
		.status_suspect_out(sus));
	osf_host osf_host_i (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so),
		.fault_out(flt));
	// System clock
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// Compare and count
	task automatic chk(input logic [NUM_OUT-1:0] got, input logic [NUM_OUT-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Wait edges, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask
	// One frame, status checked
	task automatic wr(input logic [NUM_OUT-1:0] cmd, input logic [NUM_OUT-1:0] exp);
		osf_host_i.xfer(cmd, st);
		cyc(1);
		chk(st, exp);
	endtask
	task automatic t_cmd;
		wr(8'hA5, 8'hFF);
		cyc(8);
		chk(out, 8'h5A);
		chk(flt, 8'h00);
		wr(8'hFF, 8'hA5);
		$display("done command");
	endtask
	task automatic t_open;
		sfps = 1'b0;
		// Open load only inside the filter window is not reported
		ol = 8'h81;
		cyc(4);
		ol = 8'h00;
		cyc(30);
		wr(8'hFF, 8'hFF);
		ol = 8'h81;
		cyc(30);
		wr(8'h00, 8'h7E);
		ol = 8'h00;
		$display("done open load");
	endtask
	task automatic t_oc;
		oc = 8'h01;
		cyc(8);
		chk(out, 8'hFF);
		cyc(30);
		chk(out, 8'hFE);
		// Write into a persisting short: on for the delay, then off
		wr(8'h00, 8'h01);
		cyc(5);
		chk(out, 8'hFF);
		cyc(30);
		chk(out, 8'hFE);
		oc = 8'h00;
		cyc(10);
		chk(out, 8'hFE);
		wr(8'h00, 8'h01);
		chk(flt, 8'h01);
		cyc(8);
		chk(out, 8'hFF);
		$display("done latched short");
	endtask
	task automatic t_lim;
		sfps = 1'b1;
		oc = 8'h02;
		cyc(40);
		chk(out, 8'hFF);
		wr(8'h00, 8'h02);
		oc = 8'h00;
		ot = 8'h04;
		cyc(5);
		chk(out, 8'hFB);
		ot = 8'h00;
		cyc(5);
		chk(out, 8'hFF);
		wr(8'h00, 8'h06);
		$display("done limit");
	endtask
	task automatic t_ov;
		ov = 1'b1;
		cyc(5);
		chk(out, 8'h00);
		ov = 1'b0;
		cyc(10);
		chk(out, 8'h00);
		wr(8'h00, 8'hFF);
		cyc(8);
		chk(out, 8'hFF);
		$display("done overvoltage");
	endtask
	task automatic t_uv;
		low = 1'b1;
		cyc(5);
		chk({7'h00, sus}, 8'h01);
		chk(out, 8'hFF);
		low = 1'b0;
		uv = 1'b1;
		cyc(5);
		chk(out, 8'h00);
		uv = 1'b0;
		cyc(5);
		wr(8'h00, 8'hFF);
		$display("done undervoltage");
	endtask
	// Verdict and stop
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rstn_in = 1'b0;
		sfps = 1'b1;
		{ov, uv, low} = 3'h0;
		{oc, ol, ot} = 24'h000000;
		err_total = 0;
		comparisons = 0;
		cyc(2);
		rstn_in = 1'b1;
		cyc(6);
		chk(out, 8'h00);
		t_cmd;
		t_open;
		t_oc;
		t_lim;
		t_ov;
		t_uv;
		end_sim;
	end
	// Watchdog
	initial begin
		#500000;
		err_total++;
		end_sim;
	end
endmodule
